// ===== verilog/bba_pkg.sv
package bba_pkg;

   localparam int BBA_DATA_W = 8;
   localparam int BBA_ADDR_W = 7;
   localparam int BBA_DEPTH = 128;
   localparam int BBA_NIBBLE_MSB = 3;
   localparam logic [7:0] BBA_ACC_RESET = 8'h00;
   localparam logic BBA_FLAG_RESET = 1'b0;
   localparam logic BBA_DEST_ACC = 1'b0;
   localparam logic BBA_DEST_REG = 1'b1;
   localparam logic [7:0] BBA_ONE_HOT_BASE = 8'h01;

   typedef enum logic [3:0] {
      BBA_OP_NONE,
      BBA_OP_ADD_IMM,
      BBA_OP_ADD_REG,
      BBA_OP_AND_IMM,
      BBA_OP_AND_REG,
      BBA_OP_BIT_CLR,
      BBA_OP_BIT_SET,
      BBA_OP_SKIP_ZERO,
      BBA_OP_SKIP_ONE
   } bba_op_t;

   typedef struct packed {
      bba_op_t op;
      logic [6:0] addr;
      logic [2:0] bit_idx;
      logic [7:0] imm;
      logic dest;
   } bba_instr_t;

   typedef struct packed {
      logic carry;
      logic nibble_carry_flag;
      logic zero;
   } bba_flags_t;

endpackage

// ===== verilog/bba_regfile.sv
`timescale 1ns/10ps
module bba_regfile (
   input wire logic clk, // Core clock.
   input wire logic rstn, // Synchronous reset, active low.
   input wire logic [6:0] rd_addr, // Read address.
   output logic [7:0] rd_data, // Registered read data.
   input wire logic wr_en, // Write enable.
   input wire logic [6:0] wr_addr, // Write address.
   input wire logic [7:0] wr_data // Write data.
);
   import bba_pkg::*;

   logic [7:0] mem [0:BBA_DEPTH-1];
   logic [7:0] rd_data_reg;
   logic [7:0] rd_data_next;

   // A write landing on the same edge as a read of that address is passed through,
   // so an instruction taken right after a write-back sees the new value.
   always_comb begin
      if (wr_en && (wr_addr == rd_addr)) begin
         rd_data_next = wr_data;
      end else begin
         rd_data_next = mem[rd_addr];
      end
   end

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rd_data_reg <= BBA_ACC_RESET;
      end else begin
         rd_data_reg <= rd_data_next;
      end
   end

   assign rd_data = rd_data_reg;
endmodule

// ===== verilog/bba_alu.sv
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/10ps
// Overview of operation
// RULE1: Add immediate to accumulator, store in accumulator, update carry, nibble carry, zero.
// RULE2: Add accumulator and addressed register, update carry, nibble carry, zero.
// RULE3: Destination select 0 writes accumulator, 1 writes addressed register.
// RULE4: Bit clear forces selected bit to zero, others kept, flags untouched.
// RULE5: Bit set forces selected bit to one, others kept, flags untouched.
// RULE6: AND immediate with accumulator into accumulator, update zero only.
// RULE7: AND accumulator with register, routed by destination, update zero only.
// RULE8: Skip if bit zero: discard next instruction, run no-operation, two cycles.
// RULE9: Skip if bit one: discard next instruction, run no-operation, two cycles.
// RULE10: Read-modify-write of a port register uses pin levels as source.
// RULE11: A true conditional test takes two cycles, second acting as no-operation.
// RULE12: Carry from bit 7, nibble carry from bit 3, zero when result is zero.
module bba_alu (
   input wire logic clk, // Core clock, 50 MHz.
   input wire logic rstn, // Synchronous reset, active low.
   input wire bba_pkg::bba_instr_t instr, // Decoded instruction.
   input wire logic instr_valid, // Instruction presented this cycle.
   input wire logic port_sel, // Addressed register is an I/O port.
   input wire logic [7:0] port_pins, // Levels sensed on port pins.
   output logic busy, // Block cannot accept an instruction.
   output logic [7:0] acc, // Accumulator.
   output bba_pkg::bba_flags_t flags, // Status flags.
   output logic skip_next, // Next instruction is discarded.
   output logic done, // Instruction finished, one-cycle pulse.
   output logic reg_wr, // Register write strobe to the file.
   output logic [6:0] reg_wr_addr, // Register write address.
   output logic [7:0] reg_wr_data // Register write data.
);
   import bba_pkg::*;

   typedef enum {ST_IDLE, ST_EXEC, ST_NOP} bba_state_t;

   bba_state_t state_reg, state_next;
   bba_instr_t ins_reg, ins_next;
   logic [7:0] acc_reg, acc_next;
   bba_flags_t flags_reg, flags_next;
   logic skip_reg, skip_next_v;
   logic done_reg, done_next;
   logic wr_reg, wr_next;
   logic [6:0] wr_addr_reg, wr_addr_next;
   logic [7:0] wr_data_reg, wr_data_next;
   logic port_reg, port_next;
   logic [7:0] file_rd;
   logic [7:0] src;
   logic [7:0] operand;
   logic [8:0] sum;
   logic [4:0] low_sum;
   logic [7:0] result;
   logic [7:0] bit_mask;
   logic tested_bit;
   logic busy_reg;
   logic busy_next;

   // The file read address is taken straight from the decoder so data arrive next cycle.
   bba_regfile u_regfile (
      .clk(clk),
      .rstn(rstn),
      .rd_addr(instr.addr),
      .rd_data(file_rd),
      .wr_en(wr_reg),
      .wr_addr(wr_addr_reg),
      .wr_data(wr_data_reg)
   );

   generate
      for (genvar i = 0; i < BBA_DATA_W; i++) begin : g_mask
         assign bit_mask[i] = (ins_reg.bit_idx == 3'(i));
      end
   endgenerate

   always_comb begin
      // Port registers take their source from the sensed pins, not from the file copy.
      src = port_reg ? port_pins : file_rd; // [RULE10]
      operand = (ins_reg.op == BBA_OP_ADD_IMM || ins_reg.op == BBA_OP_AND_IMM) ?
         ins_reg.imm : src;
      sum = {1'b0, acc_reg} + {1'b0, operand};
      low_sum = {1'b0, acc_reg[BBA_NIBBLE_MSB:0]} + {1'b0, operand[BBA_NIBBLE_MSB:0]};
      tested_bit = |(src & bit_mask);
   end

   always_comb begin
      state_next = state_reg;
      ins_next = ins_reg;
      acc_next = acc_reg;
      flags_next = flags_reg;
      skip_next_v = 1'b0;
      done_next = 1'b0;
      wr_next = 1'b0;
      wr_addr_next = wr_addr_reg;
      wr_data_next = wr_data_reg;
      port_next = port_reg;
      result = acc_reg;
      case (state_reg)
         ST_IDLE: begin
            if (instr_valid && instr.op != BBA_OP_NONE) begin
               ins_next = instr;
               port_next = port_sel;
               state_next = ST_EXEC;
            end
         end
         ST_EXEC: begin
            state_next = ST_IDLE;
            done_next = 1'b1;
            case (ins_reg.op)
               BBA_OP_ADD_IMM, BBA_OP_ADD_REG: begin
                  result = sum[7:0]; // [RULE1] [RULE2]
                  flags_next.carry = sum[8]; // [RULE12]
                  flags_next.nibble_carry_flag = low_sum[4]; // [RULE12]
                  flags_next.zero = (sum[7:0] == 8'h00); // [RULE12]
               end
               BBA_OP_AND_IMM, BBA_OP_AND_REG: begin
                  result = acc_reg & operand; // [RULE6] [RULE7]
                  flags_next.zero = ((acc_reg & operand) == 8'h00); // [RULE6] [RULE7]
               end
               BBA_OP_BIT_CLR: begin
                  result = src & ~bit_mask; // [RULE4]
               end
               BBA_OP_BIT_SET: begin
                  result = src | bit_mask; // [RULE5]
               end
               BBA_OP_SKIP_ZERO: begin
                  // A taken skip keeps the block busy for the discarded slot.
                  if (!tested_bit) begin
                     state_next = ST_NOP; // [RULE8] [RULE11]
                     done_next = 1'b0;
                     skip_next_v = 1'b1;
                  end
               end
               BBA_OP_SKIP_ONE: begin
                  if (tested_bit) begin
                     state_next = ST_NOP; // [RULE9] [RULE11]
                     done_next = 1'b0;
                     skip_next_v = 1'b1;
                  end
               end
               default: begin
                  result = acc_reg;
               end
            endcase
            // Immediate forms ignore the destination select.
            case (ins_reg.op)
               BBA_OP_ADD_IMM, BBA_OP_AND_IMM: begin
                  acc_next = result;
               end
               BBA_OP_ADD_REG, BBA_OP_AND_REG: begin
                  if (ins_reg.dest == BBA_DEST_ACC) begin
                     acc_next = result; // [RULE3]
                  end else begin
                     wr_next = 1'b1; // [RULE3]
                     wr_addr_next = ins_reg.addr;
                     wr_data_next = result;
                  end
               end
               BBA_OP_BIT_CLR, BBA_OP_BIT_SET: begin
                  wr_next = 1'b1;
                  wr_addr_next = ins_reg.addr;
                  wr_data_next = result;
               end
               default: begin
                  wr_next = 1'b0;
               end
            endcase
         end
         ST_NOP: begin
            // The discarded instruction's slot; nothing changes.
            state_next = ST_IDLE; // [RULE11]
            done_next = 1'b1;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // Busy follows the state being entered, so it drops on the finishing edge.
      busy_next = (state_next != ST_IDLE);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         ins_reg <= '0;
         acc_reg <= BBA_ACC_RESET;
         flags_reg <= '{BBA_FLAG_RESET, BBA_FLAG_RESET, BBA_FLAG_RESET};
         skip_reg <= 1'b0;
         done_reg <= 1'b0;
         wr_reg <= 1'b0;
         wr_addr_reg <= '0;
         wr_data_reg <= '0;
         port_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ins_reg <= ins_next;
         acc_reg <= acc_next;
         flags_reg <= flags_next;
         skip_reg <= skip_next_v;
         done_reg <= done_next;
         wr_reg <= wr_next;
         wr_addr_reg <= wr_addr_next;
         wr_data_reg <= wr_data_next;
         port_reg <= port_next;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= busy_next;
      end
   end

   assign busy = busy_reg;
   assign acc = acc_reg;
   assign flags = flags_reg;
   assign skip_next = skip_reg;
   assign done = done_reg;
   assign reg_wr = wr_reg;
   assign reg_wr_addr = wr_addr_reg;
   assign reg_wr_data = wr_data_reg;
endmodule

// ===== verif/bba_mon_monitor.sv
`timescale 1ns/10ps
module bba_mon import bba_pkg::*; (
   input wire logic clk, // Clock.
   input wire logic rstn, // Reset.
   input wire bba_instr_t instr, // Request.
   input wire logic instr_valid, // Strobe.
   input wire logic busy, // Busy.
   input wire logic [7:0] acc, // Accumulator.
   input wire bba_flags_t flags, // Flags.
   input wire logic skip_next, // Skip.
   input wire logic done, // Done.
   input wire logic reg_wr // Write.
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   wire tk = instr_valid && !busy && instr.op != BBA_OP_NONE;
   wire sk = instr.op inside {BBA_OP_SKIP_ZERO, BBA_OP_SKIP_ONE};
   wire bo = instr.op inside {BBA_OP_BIT_CLR, BBA_OP_BIT_SET};
   wire im = instr.op inside {BBA_OP_ADD_IMM, BBA_OP_AND_IMM};
   wire an = instr.op inside {BBA_OP_AND_IMM, BBA_OP_AND_REG};
   wire rr = instr.op inside {BBA_OP_ADD_REG, BBA_OP_AND_REG};
   sequence s_tail;
      busy ##1 (done && !busy);
   endsequence
   a_take_done: assert property (tk && !sk |-> ##2 done) else $error("done late");
   a_skip_tail: assert property (skip_next |-> s_tail) else $error("bad skip");
   a_bit_flags: assert property (tk && (bo || sk) |=> $stable(flags)[*3])
      else $error("flags moved");
   a_and_carry: assert property (tk && an |=> $stable(flags[2:1])[*2])
      else $error("carry moved");
   a_wr_dest: assert property (tk && rr && instr.dest |-> ##2 reg_wr)
      else $error("no write");
   a_wr_none: assert property (tk && (im || sk) |-> ##2 !reg_wr)
      else $error("bad write");
   a_bit_write: assert property (tk && bo |-> ##2 reg_wr) else $error("no bit write");
   a_zero_acc: assert property (tk && im |-> ##2 flags.zero == (acc == 8'h00))
      else $error("bad zero");
   a_done_pulse: assert property (done |=> !done) else $error("long done");
   a_busy_span: assert property (tk && !sk |=> busy ##1 !busy)
      else $error("bad busy");
endmodule
bind bba_alu bba_mon u_mon (.clk, .rstn, .instr, .instr_valid, .busy, .acc, .flags,
   .skip_next, .done, .reg_wr);

// ===== verif/bba_dec_model.sv
`timescale 1ns/10ps
module bba_dec_model import bba_pkg::*; (
   input wire logic clk, // Clock.
   input wire logic go, // Issue pulse.
   input wire bba_instr_t req, // Next request.
   input wire logic sel, // Port source.
   input wire logic [7:0] pins, // Pin levels.
   input wire logic done, // Block done.
   output bba_instr_t instr, // Held request.
   output logic instr_valid, // Issue strobe.
   output logic port_sel, // Port source.
   output logic [7:0] port_pins // Pins seen.
);
   initial {instr, instr_valid, port_sel, port_pins} = '0;
   // Pins are not held after use, so stale levels are inverted.
   always @(posedge clk) begin
      instr_valid <= go;
      if (go) begin
         {instr, port_sel, port_pins} <= {req, sel, pins};
      end else if (done) begin
         port_pins <= ~port_pins;
      end
   end
endmodule

// ===== verif/testbench.sv
`timescale 1ns/10ps
module testbench;
   import bba_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, go = 1'b0, sel = 1'b0, sk_seen = 1'b0;
   logic busy, instr_valid, port_sel, skip_next, done, reg_wr;
   logic [7:0] pins = 8'h00, acc, port_pins, reg_wr_data, acc_m = 8'h00;
   logic [6:0] reg_wr_addr;
   bba_instr_t req = '0, instr;
   bba_flags_t flags, flg_m = '0;
   logic [7:0] mem [128];
   logic [27:0] notes [$];
   logic [31:0] rv;
   int failures = 0, checked = 0, seed = 32'h8ba6e547, i;
   always #10 clk = ~clk;
   bba_dec_model u_dec (.clk, .go, .req, .sel, .pins, .done, .instr, .instr_valid,
      .port_sel, .port_pins);
   bba_alu u_dut (.clk, .rstn, .instr, .instr_valid, .port_sel, .port_pins, .busy, .acc,
      .flags, .skip_next, .done, .reg_wr, .reg_wr_addr, .reg_wr_data);
   task automatic chk(logic [27:0] e, logic [27:0] g);
      checked++;
      if (e !== g) begin
         failures++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic final_report;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic run(bba_op_t op, logic [6:0] a, logic [2:0] b, logic [7:0] k, logic d, logic s);
      logic [7:0] p, src, o, r;
      logic [8:0] sum;
      logic [4:0] nb;
      logic wr, sk;
      bba_flags_t f;
      int n;
      p = 8'($random(seed));
      src = s ? p : mem[a];
      o = (op inside {BBA_OP_ADD_IMM, BBA_OP_AND_IMM}) ? k : src;
      sum = {1'b0, acc_m} + {1'b0, o};
      nb = {1'b0, acc_m[3:0]} + {1'b0, o[3:0]};
      {wr, sk, r, f} = {2'b00, acc_m & o, flg_m};
      case (op)
         BBA_OP_ADD_IMM, BBA_OP_ADD_REG: begin
            r = sum[7:0];
            f = {sum[8], nb[4], r == 8'h00};
         end
         BBA_OP_AND_IMM, BBA_OP_AND_REG: f.zero = (r == 8'h00);
         BBA_OP_BIT_CLR: {wr, r} = {1'b1, src & ~(8'h01 << b)};
         BBA_OP_BIT_SET: {wr, r} = {1'b1, src | (8'h01 << b)};
         BBA_OP_SKIP_ZERO: sk = !src[b];
         default: sk = src[b];
      endcase
      if (op inside {BBA_OP_ADD_REG, BBA_OP_AND_REG}) wr = d;
      if (wr) mem[a] = r;
      else if (!sk && op < BBA_OP_BIT_CLR) acc_m = r;
      flg_m = f;
      notes.push_back({sk, acc_m, flg_m, wr, wr ? {a, r} : 15'h0});
      @(posedge clk);
      {req, sel, pins, go} <= {op, a, b, k, d, s, p, 1'b1};
      @(posedge clk);
      go <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 9) begin
         @(posedge clk);
         n++;
      end
      if (n >= 9) begin
         failures++;
         final_report;
      end
   endtask
   always @(posedge clk) begin
      if (rstn && done === 1'b1) begin
         chk(notes.size() > 0 ? notes.pop_front() : 'x,
            {sk_seen, acc, flags, reg_wr, reg_wr ? {reg_wr_addr, reg_wr_data} : 15'h0});
      end
      sk_seen <= skip_next;
   end
   initial begin
      repeat (6) @(posedge clk);
      chk(28'h0, 28'({acc, flags}));
      rstn <= 1'b1;
      run(BBA_OP_ADD_IMM, 7'h00, 3'h0, 8'hff, 1'b0, 1'b1);
      run(BBA_OP_ADD_IMM, 7'h00, 3'h0, 8'h01, 1'b0, 1'b1);
      run(BBA_OP_ADD_REG, 7'h05, 3'h0, 8'h00, 1'b1, 1'b1);
      run(BBA_OP_AND_REG, 7'h05, 3'h0, 8'h00, 1'b0, 1'b0);
      // Every register gets a known value from the pins before random file reads.
      for (i = 0; i < 128; i++) begin
         run(BBA_OP_BIT_SET, 7'(i), 3'(i), 8'h00, 1'b0, 1'b1);
      end
      for (i = 0; i < 300; i++) begin
         rv = $random(seed);
         run(bba_op_t'({1'b0, rv[2:0]} + 4'h1), rv[9:3], rv[12:10], rv[20:13], rv[21],
            rv[22]);
      end
      final_report;
   end
endmodule
